//--- core/ccti_core.sv
`include "ccti_defines.svh"

// Contract
// - A nominal bit is combined quanta plus second phase plus one sync quantum.
// - The sync segment is exactly one quantum, added implicitly.
// - Quantum is the module clock divided by the programmed divider.
// - Combined length, second phase and jump width are held separately.
// - Software reads back bit timing with the meaning it wrote.
// - Disabling stops traffic handling but keeps all state intact; the code holds the bit clock counters at zero instead.
// - Enabling lets pending frames transmit and received frames be processed.
// - After reset, message processing is disabled.
// - Error counts are readable with an error-passive flag.
// - Software clears the status interrupt or one object interrupt by code.
// - Reading status clears a pending status interrupt.
// - Reading a message object clears its pending interrupt.
// - Error, status and global enables are set and cleared individually.
// - Nothing interrupts without the global enable.
// - Object transfers interrupt only with the object's own enable set.
// - Error interrupt on entering bus-off or an error limit.
// - Status interrupt on transfer completion or bus error.
// - Cause reads the status code, else the best pending object 1-32.
// - Lower object numbers have higher priority.
module ccti_core #(
	parameter int NUM_OBJ = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic txDoneEvt,
	input wire logic busErrEvt,
	input wire logic busOff,
	input wire logic errWarn,
	input wire ccti_pkg::ccti_cnt_t rxErrCount,
	input wire ccti_pkg::ccti_cnt_t txErrCount,
	input wire logic [NUM_OBJ-1:0] objEvent,
	input wire logic objReadStrobe,
	input wire logic [4:0] objReadIdx,
	output logic procEnable,
	output ccti_pkg::ccti_pp_t propAndFirstPhaseQuanta,
	output ccti_pkg::ccti_ph2_t secondPhaseQuanta,
	output ccti_pkg::ccti_sjw_t resyncJumpWidth,
	output ccti_pkg::ccti_div_t quantumClockDivider,
	output logic quantumTick,
	output logic bitStart,
	output logic samplePoint,
	output logic irq
);
	import ccti_pkg::*;

	// ************************************************************
	// Local state.
	// ************************************************************
	logic errIntEn;
	logic statIntEn;
	logic globIntEn;
	logic [NUM_OBJ-1:0] objIntEn;
	logic [NUM_OBJ-1:0] objPend;
	logic statPend;
	logic errPend;
	logic txOkSeen;
	logic busErrSeen;
	logic busOffDly;
	logic warnDly;
	logic errPassive;
	logic setupPhase;
	logic accessPhase;
	logic wrAccess;
	logic rdAccess;
	logic addrHit;
	logic [31:0] next_prdata;
	logic [NUM_OBJ-1:0] objClr;
	logic statClr;
	logic errEvt;
	logic statEvt;
	ccti_cause_t causeCode;

	// ************************************************************
	// Helpers.
	// ************************************************************

	// Lowest numbered pending object wins; returns its 1-based number.
	function automatic ccti_cause_t lowest_pending(
		input logic [NUM_OBJ-1:0] pend
	);
		ccti_cause_t num;
		num = `CCTI_CAUSE_NONE;
		for (int i = NUM_OBJ - 1; i >= 0; i--) begin
			if (pend[i]) begin
				num = 16'(i + 1);
			end
		end
		return num;
	endfunction

	// True when the address names a mapped register.
	function automatic logic is_mapped(input logic [7:0] addr);
		logic hit;
		hit = 1'b0;
		unique case (addr)
			`CCTI_OFF_CTRL, `CCTI_OFF_BITTIM, `CCTI_OFF_ERRCNT,
			`CCTI_OFF_STATUS, `CCTI_OFF_CAUSE, `CCTI_OFF_INTCLR,
			`CCTI_OFF_OBJPEND, `CCTI_OFF_OBJIE: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	// ************************************************************
	// APB phase decode.
	// ************************************************************

	// The slave never inserts wait states, so the access phase is one cycle.
	assign pready = 1'b1;
	assign setupPhase = psel && !penable;
	assign accessPhase = psel && penable;
	assign addrHit = is_mapped(paddr);
	assign wrAccess = accessPhase && pwrite && addrHit;
	assign rdAccess = accessPhase && !pwrite && addrHit;
	assign pslverr = accessPhase && !addrHit;

	// ************************************************************
	// Control and timing registers.
	// ************************************************************

	// Run and interrupt enables; each bit is written on its own position.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			procEnable <= 1'b0;
			errIntEn <= 1'b0;
			statIntEn <= 1'b0;
			globIntEn <= 1'b0;
		end else if (wrAccess && paddr == `CCTI_OFF_CTRL) begin
			// Clearing run zeroes the bit clock counters; registers outside this word are untouched.
			procEnable <= pwdata[`CCTI_CTRL_RUN];
			errIntEn <= pwdata[`CCTI_CTRL_ERRIE];
			statIntEn <= pwdata[`CCTI_CTRL_STATIE];
			globIntEn <= pwdata[`CCTI_CTRL_GLOBIE];
		end
	end

	// Bit timing fields are kept apart and read back as stored.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			propAndFirstPhaseQuanta <= `CCTI_BT_PP_RST;
			secondPhaseQuanta <= `CCTI_BT_PH2_RST;
			resyncJumpWidth <= `CCTI_BT_SJW_RST;
			quantumClockDivider <= `CCTI_BT_DIV_RST;
		end else if (wrAccess && paddr == `CCTI_OFF_BITTIM) begin
			propAndFirstPhaseQuanta <= pwdata[`CCTI_BT_PP_LSB +: 6];
			secondPhaseQuanta <= pwdata[`CCTI_BT_PH2_LSB +: 4];
			resyncJumpWidth <= pwdata[`CCTI_BT_SJW_LSB +: 2];
			quantumClockDivider <= pwdata[`CCTI_BT_DIV_LSB +: 10];
		end
	end

	// Per-object interrupt enables.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			objIntEn <= '0;
		end else if (wrAccess && paddr == `CCTI_OFF_OBJIE) begin
			objIntEn <= pwdata[NUM_OBJ-1:0];
		end
	end

	// ************************************************************
	// Event capture.
	// ************************************************************

	// Edge detect on the error levels so one entry gives one event.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busOffDly <= 1'b0;
			warnDly <= 1'b0;
		end else begin
			busOffDly <= busOff;
			warnDly <= errWarn;
		end
	end

	assign errEvt = (busOff && !busOffDly) || (errWarn && !warnDly);
	assign statEvt = txDoneEvt || busErrEvt;
	assign errPassive = rxErrCount >= `CCTI_ERR_PASSIVE_LIMIT;

	// Clear strobes from the clear register, status reads and object reads.
	assign statClr = (wrAccess && paddr == `CCTI_OFF_INTCLR
		&& pwdata[15:0] == `CCTI_CAUSE_STATUS)
		|| (rdAccess && paddr == `CCTI_OFF_STATUS);

	// One clear line per object, from a cleared code or an object read.
	for (genvar g = 0; g < NUM_OBJ; g++) begin : gObjClr
		assign objClr[g] = (wrAccess && paddr == `CCTI_OFF_INTCLR
			&& pwdata[15:0] == 16'(g + 1))
			|| (objReadStrobe && objReadIdx == 5'(g));
	end

	// Object pending bits; a new transfer beats a clear in the same cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			objPend <= '0;
		end else begin
			objPend <= (objPend & ~objClr) | (objEvent & objIntEn);
		end
	end

	// Status-class pending and the latched event bits behind it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			statPend <= 1'b0;
			errPend <= 1'b0;
			txOkSeen <= 1'b0;
			busErrSeen <= 1'b0;
		end else begin
			statPend <= (statPend && !statClr) || statEvt;
			errPend <= (errPend && !statClr) || errEvt;
			txOkSeen <= (txOkSeen && !statClr) || txDoneEvt;
			busErrSeen <= (busErrSeen && !statClr) || busErrEvt;
		end
	end

	// ************************************************************
	// Cause and interrupt.
	// ************************************************************

	// Status cause first, else the lowest numbered pending object.
	always_comb begin
		if ((statPend && statIntEn) || (errPend && errIntEn)) begin
			causeCode = `CCTI_CAUSE_STATUS;
		end else begin
			causeCode = lowest_pending(objPend);
		end
	end

	// Registered level output; it drops one cycle after the last enabled source clears.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= globIntEn && ((errIntEn && errPend)
				|| (statIntEn && statPend)
				|| (|objPend));
		end
	end

	// ************************************************************
	// Read data.
	// ************************************************************

	// Read data is captured in the setup cycle, so the access cycle
	// returns a stable registered word with no wait state.
	always_comb begin
		next_prdata = 32'h0000_0000;
		unique case (paddr)
			`CCTI_OFF_CTRL: begin
				next_prdata[`CCTI_CTRL_RUN] = procEnable;
				next_prdata[`CCTI_CTRL_ERRIE] = errIntEn;
				next_prdata[`CCTI_CTRL_STATIE] = statIntEn;
				next_prdata[`CCTI_CTRL_GLOBIE] = globIntEn;
			end
			`CCTI_OFF_BITTIM: begin
				next_prdata[`CCTI_BT_PP_LSB +: 6] = propAndFirstPhaseQuanta;
				next_prdata[`CCTI_BT_PH2_LSB +: 4] = secondPhaseQuanta;
				next_prdata[`CCTI_BT_SJW_LSB +: 2] = resyncJumpWidth;
				next_prdata[`CCTI_BT_DIV_LSB +: 10] = quantumClockDivider;
			end
			`CCTI_OFF_ERRCNT: begin
				next_prdata[7:0] = rxErrCount;
				next_prdata[15:8] = txErrCount;
				next_prdata[16] = errPassive;
			end
			`CCTI_OFF_STATUS: begin
				next_prdata[`CCTI_ST_TXOK] = txOkSeen;
				next_prdata[`CCTI_ST_BUSERR] = busErrSeen;
				next_prdata[`CCTI_ST_BUSOFF] = busOff;
				next_prdata[`CCTI_ST_PASSIVE] = errPassive;
				next_prdata[`CCTI_ST_WARN] = errWarn;
			end
			`CCTI_OFF_CAUSE: begin
				next_prdata[15:0] = causeCode;
			end
			`CCTI_OFF_OBJPEND: begin
				next_prdata[NUM_OBJ-1:0] = objPend;
			end
			`CCTI_OFF_OBJIE: begin
				next_prdata[NUM_OBJ-1:0] = objIntEn;
			end
			default: begin
				next_prdata = 32'h0000_0000;
			end
		endcase
	end

	// Unmapped and write-only addresses read as zero.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (setupPhase && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// ************************************************************
	// Quantum and bit clock.
	// ************************************************************

	// The bit clock only runs while processing is enabled.
	ccti_bit_clock uBitClock (
		.clk(clk),
		.rst(rst),
		.run(procEnable),
		.divider(quantumClockDivider),
		.propPhase1(propAndFirstPhaseQuanta),
		.phase2(secondPhaseQuanta),
		.quantumTick(quantumTick),
		.bitStart(bitStart),
		.samplePoint(samplePoint)
	);

endmodule

//--- common/ccti_defines.svh
`ifndef CCTI_DEFINES_SVH
`define CCTI_DEFINES_SVH

// ****************************************************************
// Register byte offsets on the APB side.
// ****************************************************************
`define CCTI_OFF_CTRL 8'h00
`define CCTI_OFF_BITTIM 8'h04
`define CCTI_OFF_ERRCNT 8'h08
`define CCTI_OFF_STATUS 8'h0c
`define CCTI_OFF_CAUSE 8'h10
`define CCTI_OFF_INTCLR 8'h14
`define CCTI_OFF_OBJPEND 8'h18
`define CCTI_OFF_OBJIE 8'h1c

// ****************************************************************
// Control register fields.
// ****************************************************************
`define CCTI_CTRL_RUN 0
`define CCTI_CTRL_ERRIE 1
`define CCTI_CTRL_STATIE 2
`define CCTI_CTRL_GLOBIE 3

// ****************************************************************
// Bit timing register fields and reset values.
// ****************************************************************
`define CCTI_BT_PP_LSB 0
`define CCTI_BT_PH2_LSB 8
`define CCTI_BT_SJW_LSB 12
`define CCTI_BT_DIV_LSB 16
`define CCTI_BT_PP_RST 6'h04
`define CCTI_BT_PH2_RST 4'h1
`define CCTI_BT_SJW_RST 2'h0
`define CCTI_BT_DIV_RST 10'h001

// ****************************************************************
// Status register fields, limits and cause codes.
// ****************************************************************
`define CCTI_ST_TXOK 0
`define CCTI_ST_BUSERR 1
`define CCTI_ST_BUSOFF 2
`define CCTI_ST_PASSIVE 3
`define CCTI_ST_WARN 4
`define CCTI_ERR_PASSIVE_LIMIT 8'h80
`define CCTI_CAUSE_STATUS 16'h8000
`define CCTI_CAUSE_NONE 16'h0000

`endif

//--- common/ccti_pkg.sv
package ccti_pkg;

	// Field types shared by the core and the bit clock.
	typedef logic [5:0] ccti_pp_t;
	typedef logic [3:0] ccti_ph2_t;
	typedef logic [1:0] ccti_sjw_t;
	typedef logic [9:0] ccti_div_t;
	typedef logic [7:0] ccti_cnt_t;
	typedef logic [15:0] ccti_cause_t;

endpackage

//--- core/ccti_bit_clock.sv
`include "ccti_defines.svh"

module ccti_bit_clock (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire ccti_pkg::ccti_div_t divider,
	input wire ccti_pkg::ccti_pp_t propPhase1,
	input wire ccti_pkg::ccti_ph2_t phase2,
	output logic quantumTick,
	output logic bitStart,
	output logic samplePoint
);
	import ccti_pkg::*;

	ccti_div_t divCnt;
	logic [6:0] quantaCnt;
	logic [6:0] bitQuanta;
	logic divWrap;
	logic bitWrap;

	// A divider of zero is taken as one so the quantum never stalls.
	assign divWrap = (divider == 10'h000) || (divCnt == divider - 10'h001);
	// Sync quantum plus the combined and second phase lengths.
	assign bitQuanta = 7'(propPhase1) + 7'(phase2) + 7'h01;
	assign bitWrap = (quantaCnt == bitQuanta - 7'h01);

	// Module clock divided down to one time quantum.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			divCnt <= 10'h000;
		end else if (!run || divWrap) begin
			divCnt <= 10'h000;
		end else begin
			divCnt <= divCnt + 10'h001;
		end
	end

	// Quantum index within the nominal bit; index zero is the sync slot.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			quantaCnt <= 7'h00;
		end else if (!run) begin
			quantaCnt <= 7'h00;
		end else if (divWrap) begin
			quantaCnt <= bitWrap ? 7'h00 : quantaCnt + 7'h01;
		end
	end

	// Strobes are registered so the engine sees clean one-cycle pulses.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			quantumTick <= 1'b0;
			bitStart <= 1'b0;
			samplePoint <= 1'b0;
		end else begin
			quantumTick <= run && divWrap;
			bitStart <= run && divWrap && (quantaCnt == 7'h00);
			samplePoint <= run && divWrap && (quantaCnt == 7'(propPhase1));
		end
	end

endmodule

//--- sim/ccti_asserts.sv
module ccti_asserts import ccti_pkg::*; #(
	parameter int NUM_OBJ = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic procEnable,
	input wire logic irq,
	input wire ccti_pkg::ccti_pp_t propAndFirstPhaseQuanta,
	input wire ccti_pkg::ccti_ph2_t secondPhaseQuanta,
	input wire ccti_pkg::ccti_div_t quantumClockDivider,
	input wire logic quantumTick,
	input wire logic bitStart,
	input wire logic samplePoint
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****
	// Checks.
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Writes in the access phase, and a bit under the bench timing.
	sequence ctrl_wr;
		psel && penable && pwrite && paddr == 8'h00;
	endsequence
	sequence bt_wr;
		psel && penable && pwrite && paddr == 8'h04;
	endsequence
	sequence bit_fixed;
		bitStart && propAndFirstPhaseQuanta == 6'h02 &&
			secondPhaseQuanta == 4'h1 && quantumClockDivider == 10'h002;
	endsequence

	reset_idle_a: assert property ($fell(rst) |-> !procEnable && !irq)
		else $error("busy after reset");
	unmapped_err_a: assert property (psel && penable && paddr[1:0] == 0
		|-> pslverr == (paddr > 8'h1c)) else $error("bad pslverr");
	run_on_a: assert property (ctrl_wr ##0 pwdata[0] |=> procEnable)
		else $error("run not set");
	timing_write_a: assert property (bt_wr |=>
		quantumClockDivider == $past(pwdata[25:16]) &&
		propAndFirstPhaseQuanta == $past(pwdata[5:0]))
		else $error("timing not taken");
	global_gate_a: assert property (ctrl_wr ##0 !pwdata[3] |-> ##2 !irq)
		else $error("irq without global");
	stop_ticks_a: assert property (!procEnable [*3] |->
		!quantumTick && !bitStart && !samplePoint) else $error("ticks");
	tick_period_a: assert property (quantumTick &&
		quantumClockDivider == 10'h002 ##1 procEnable [*2] |->
		quantumTick && !$past(quantumTick)) else $error("tick period");
	bit_period_a: assert property (bit_fixed ##1 procEnable [*8]
		|-> bitStart) else $error("bit length");
	sample_point_a: assert property (bit_fixed ##1 procEnable [*4]
		|-> samplePoint) else $error("sample point");
endmodule

bind ccti_core ccti_asserts #(.NUM_OBJ(NUM_OBJ)) chk_u (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pslverr(pslverr), .procEnable(procEnable), .irq(irq),
	.propAndFirstPhaseQuanta(propAndFirstPhaseQuanta),
	.secondPhaseQuanta(secondPhaseQuanta),
	.quantumClockDivider(quantumClockDivider),
	.quantumTick(quantumTick), .bitStart(bitStart),
	.samplePoint(samplePoint)
);

//--- sim/ccti_node_model.sv
module ccti_node_model import ccti_pkg::*; #(
	parameter ccti_cnt_t WARN = 8'h60
) (
	input wire logic clk,
	input wire logic procEnable,
	output logic txDoneEvt,
	output logic busErrEvt,
	output logic busOff,
	output logic errWarn,
	output ccti_pkg::ccti_cnt_t rxErrCount,
	output ccti_pkg::ccti_cnt_t txErrCount,
	output logic [31:0] objEvent
);
	timeunit 1ns;
	timeprecision 100ps;

	// The far nodes start quiet with clean counters.
	initial begin
		txDoneEvt = 1'b0;
		busErrEvt = 1'b0;
		busOff = 1'b0;
		errWarn = 1'b0;
		rxErrCount = 8'h00;
		txErrCount = 8'h00;
		objEvent = '0;
	end

	// A frame ends on the bus only while the controller takes part.
	// Object 0 means a frame with no object event.
	task automatic frame(input int idx, input logic err);
		@(posedge clk);
		if (procEnable) begin
			if (idx > 0)
				objEvent[idx - 1] <= 1'b1;
			txDoneEvt <= !err;
			busErrEvt <= err;
		end
		@(posedge clk);
		objEvent <= '0;
		txDoneEvt <= 1'b0;
		busErrEvt <= 1'b0;
	endtask

	// Counters move as faults are seen; warn follows a limit.
	task automatic errs(input ccti_cnt_t rx, input ccti_cnt_t tx,
		input logic off);
		@(posedge clk);
		rxErrCount <= rx;
		txErrCount <= tx;
		busOff <= off;
		errWarn <= rx >= WARN || tx >= WARN;
	endtask
endmodule

//--- sim/can_timing_interrupt_control_tb.sv
module can_timing_interrupt_control_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, run, e;
	logic txd, bue, boff, warn, objRd, bs;
	logic [4:0] objIdx;
	logic [1:0] sjw;
	logic [7:0] paddr, rxc, txc;
	logic [31:0] pwdata, prdata, seed, v, r, ie, obj;
	int num_errors, checks, n;

	ccti_core dut_u (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .txDoneEvt(txd),
		.busErrEvt(bue), .busOff(boff), .errWarn(warn), .rxErrCount(rxc),
		.txErrCount(txc), .objEvent(obj), .objReadStrobe(objRd),
		.objReadIdx(objIdx), .procEnable(run),
		.propAndFirstPhaseQuanta(), .secondPhaseQuanta(),
		.resyncJumpWidth(sjw), .quantumClockDivider(), .quantumTick(),
		.bitStart(bs), .samplePoint(), .irq(irq)
	);
	ccti_node_model node_u (
		.clk(clk), .procEnable(run), .txDoneEvt(txd), .busErrEvt(bue),
		.busOff(boff), .errWarn(warn), .rxErrCount(rxc),
		.txErrCount(txc), .objEvent(obj)
	);

	// ****
	// Helpers.
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] btExp(input logic [31:0] w);
		return w & 32'h03ff_3f3f;
	endfunction
	function automatic logic [31:0] errExp(input logic [7:0] rx, tx);
		return {15'h0, rx >= 8'h80, tx, rx};
	endfunction

	task automatic results();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] x);
		checks++;
		if (got !== x) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, x);
		end
	endtask

	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			results();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask

	// Pending flags and irq are each one register stage behind.
	task automatic ci(input logic x);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, {31'h0, x});
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		results();
	end

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		objRd = 1'b0;
		objIdx = 5'h00;
		num_errors = 0;
		checks = 0;
		seed = 32'hf5c7f797;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rc(8'h00, 32'h0);
		rc(8'h04, 32'h0001_0104);
		// Random timing words read back while stopped.
		repeat (4) begin
			seed = lfsr(seed);
			v = seed | 32'h0001_0000;
			apb(1'b1, 8'h04, v);
			rc(8'h04, btExp(v));
			chk({30'h0, sjw}, {30'h0, v[13:12]});
		end
		rc(8'h24, 32'h0);
		chk({31'h0, e}, 32'h1);
		// Error counts either side of the passive limit, then random.
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			v = i == 0 ? 32'h7f : i == 1 ? 32'h80 : seed;
			node_u.errs(v[7:0], seed[15:8], 1'b0);
			rc(8'h08, errExp(v[7:0], seed[15:8]));
		end
		node_u.errs(8'h00, 8'h00, 1'b0);
		apb(1'b1, 8'h14, 32'h8000);
		// Object interrupts: 2 masked, 5 and 9 enabled.
		ie = lfsr(seed) & 32'hffff_fffd | 32'h0000_0110;
		apb(1'b1, 8'h1c, ie);
		apb(1'b1, 8'h00, 32'h9);
		node_u.frame(2, 1'b0);
		ci(1'b0);
		node_u.frame(9, 1'b0);
		node_u.frame(5, 1'b0);
		ci(1'b1);
		rc(8'h10, 32'h5);
		apb(1'b1, 8'h14, 32'h5);
		rc(8'h10, 32'h9);
		objIdx <= 5'h08;
		objRd <= 1'b1;
		@(posedge clk);
		objRd <= 1'b0;
		ci(1'b0);
		apb(1'b1, 8'h00, 32'h1);
		node_u.frame(5, 1'b0);
		ci(1'b0);
		apb(1'b1, 8'h00, 32'h9);
		ci(1'b1);
		apb(1'b1, 8'h14, 32'h5);
		// Status source: completion, then bus error.
		apb(1'b1, 8'h14, 32'h8000);
		apb(1'b1, 8'h00, 32'hd);
		ci(1'b0);
		node_u.frame(0, 1'b0);
		ci(1'b1);
		rc(8'h10, 32'h8000);
		rc(8'h0c, 32'h1);
		ci(1'b0);
		node_u.frame(0, 1'b1);
		ci(1'b1);
		rc(8'h0c, 32'h2);
		ci(1'b0);
		// A clear by code drops the pending flag and the sticky bits too.
		node_u.frame(0, 1'b1);
		ci(1'b1);
		apb(1'b1, 8'h14, 32'h8000);
		ci(1'b0);
		// Error source: bus-off, then a counter limit.
		apb(1'b1, 8'h00, 32'hb);
		node_u.errs(8'h00, 8'h00, 1'b1);
		ci(1'b1);
		rc(8'h0c, 32'h4);
		ci(1'b0);
		node_u.errs(8'h60, 8'h00, 1'b1);
		ci(1'b1);
		// Bit clock: 4 quanta of 2 clocks, set while stopped.
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'h0002_0102);
		apb(1'b1, 8'h00, 32'h1);
		repeat (16) @(posedge clk);
		n = 0;
		repeat (64) begin
			@(posedge clk);
			n += int'(bs);
		end
		chk(n, 32'h8);
		apb(1'b1, 8'h00, 32'h0);
		rc(8'h04, 32'h0002_0102);
		rc(8'h1c, ie);
		results();
	end
endmodule
